// >>> shared/dor_map.vh
// Constants for the digital output control and routing block
`ifndef DOR_MAP_VH
`define DOR_MAP_VH

// ----------------------------------------
// Output value word bit positions
// ----------------------------------------
`define DOR_BRAKE_BIT 0
`define DOR_SPECIAL_LAST 15
`define DOR_OUT1_BIT 16
`define DOR_NUM_OUT 4
`define DOR_APPLIED_MASK 32'h000f_0001

// ----------------------------------------
// Routing entry layout
// ----------------------------------------
`define DOR_NUM_ROUTE 5
`define DOR_SRC_MSB 15
`define DOR_SRC_LSB 8
`define DOR_GATE_INV_BIT 7
`define DOR_GATE_IDX_MSB 6
`define DOR_GATE_IDX_LSB 0
`define DOR_ROUTE_RESET 16'h0100

// ----------------------------------------
// Source codes
// ----------------------------------------
`define DOR_SRC_ONE 8'h00
`define DOR_SRC_ZERO 8'h01
`define DOR_SRC_ENC_FIRST 8'h02
`define DOR_SRC_ENC_LAST 8'h08
`define DOR_SRC_POS_FIRST 8'h09
`define DOR_SRC_POS_LAST 8'h0f

// ----------------------------------------
// Reset values of the settings
// ----------------------------------------
`define DOR_READBACK_RESET 32'h0000_0000
`define DOR_PIN_RELEASED 1'b0

// ----------------------------------------
// Output rate limits
// ----------------------------------------
`define DOR_CLK_HZ 200000000
`define DOR_PWM_MAX_HZ 2000
`define DOR_OUT_MAX_HZ 500
`define DOR_PWM_PERIOD_CYC (`DOR_CLK_HZ / `DOR_PWM_MAX_HZ)
`define DOR_OUT_PERIOD_CYC (`DOR_CLK_HZ / `DOR_OUT_MAX_HZ)
`define DOR_HOLD_W 19

`endif

// >>> src/dor_output_routing.v
// Digital output stage with polarity, manual forcing, readback and routing
// Functional notes
// - Output n follows bit 15+n of the output value word.
// - Bits 0..15 are special; only bit 0 is used, driving the brake.
// - Polarity bit set makes a one in the value word drive a low level.
// - Manual-enable bits take the level from the manual-value bits, brake included.
// - Readback shows the pattern applied after polarity and manual forcing.
// - Routing enable switches to routing; polarity and manual settings then ignored.
// - Five routing entries: software PWM, then outputs 1 to 4.
// - Entry is 16 bits: high byte source, low byte gating control bit.
// - Entry bit 7 inverts the gate: a zero control bit then enables.
// - Source 00 holds the output at one, 01 holds it at zero.
// - Sources 02..08 are encoder increments divided by 1 to 64.
// - Sources 09..0F are position increments divided by 1 to 64.
// - With divider 1 every increment outside the hold-off window yields one output pulse.
// - Encoder sources give no pulses unless a real encoder is fitted.
// - PWM output runs up to 2 kHz, other routed outputs up to 500 Hz.
`timescale 1ns/1ps
`include "dor_map.vh"

module dor_output_routing #(
    parameter PWM_PERIOD_CYC = `DOR_PWM_PERIOD_CYC,
    parameter OUT_PERIOD_CYC = `DOR_OUT_PERIOD_CYC
) (
    input wire ref_clk,
    input wire srst,
    input wire [31:0] output_value_word,
    input wire [31:0] routing_gate_control_word,
    input wire [31:0] output_polarity_select,
    input wire [31:0] output_manual_enable,
    input wire [31:0] output_manual_value,
    input wire [31:0] output_routing_enable,
    input wire [15:0] route_pwm_output,
    input wire [15:0] route_output_one,
    input wire [15:0] route_output_two,
    input wire [15:0] route_output_three,
    input wire [15:0] route_output_four,
    input wire [4:0] route_write,
    input wire encoder_fitted,
    input wire encoder_inc,
    input wire position_inc,
    output reg [31:0] output_applied_readback,
    output reg brake_o,
    output reg brake_oe,
    output reg [3:0] out_o,
    output reg [3:0] out_oe,
    output reg pwm_out
);

    // ----------------------------------------
    // Normal mode pattern
    // ----------------------------------------
    wire [31:0] polar_word;
    wire [31:0] normal_word;
    wire routing_on;

    assign polar_word = output_value_word ^ output_polarity_select;
    assign normal_word = ((polar_word & ~output_manual_enable)
        | (output_manual_value & output_manual_enable)) & `DOR_APPLIED_MASK;
    assign routing_on = output_routing_enable[0];

    // ----------------------------------------
    // Routing channels
    // ----------------------------------------
    wire [16*`DOR_NUM_ROUTE-1:0] route_flat;
    wire [`DOR_NUM_ROUTE-1:0] route_level;

    assign route_flat = {route_output_four, route_output_three, route_output_two,
        route_output_one, route_pwm_output};

    genvar ch;
    generate
        for (ch = 0; ch < `DOR_NUM_ROUTE; ch = ch + 1)
        begin : g_route
            wire [15:0] entry;
            wire [7:0] src;
            wire [6:0] gate_idx;
            wire gate_bit;
            wire gate_ok;
            wire is_enc;
            wire is_pos;
            wire [2:0] div_sel;
            wire [5:0] div_last;
            wire inc;
            reg [5:0] div_cnt;
            reg [`DOR_HOLD_W-1:0] hold;
            wire [`DOR_HOLD_W-1:0] period;
            wire div_pulse;

            assign entry = route_flat[16*ch+15:16*ch];
            assign src = entry[`DOR_SRC_MSB:`DOR_SRC_LSB];
            assign gate_idx = entry[`DOR_GATE_IDX_MSB:`DOR_GATE_IDX_LSB];
            // Control word is 32 bits; higher indexes read as zero
            assign gate_bit = (gate_idx < 7'd32) ? routing_gate_control_word[gate_idx[4:0]]
                : 1'b0;
            assign gate_ok = gate_bit ^ entry[`DOR_GATE_INV_BIT];
            assign is_enc = (src >= `DOR_SRC_ENC_FIRST) && (src <= `DOR_SRC_ENC_LAST);
            assign is_pos = (src >= `DOR_SRC_POS_FIRST) && (src <= `DOR_SRC_POS_LAST);
            assign div_sel = is_enc ? src[2:0] - 3'd2 : src[2:0] - 3'd1;
            assign div_last = (6'd1 << div_sel) - 6'd1;
            assign inc = (is_enc & encoder_inc & encoder_fitted) | (is_pos & position_inc);
            assign div_pulse = inc && (div_cnt == div_last);
            // Hold-off caps the output rate; the PWM channel may run faster
            assign period = (ch == 0) ? PWM_PERIOD_CYC[`DOR_HOLD_W-1:0]
                : OUT_PERIOD_CYC[`DOR_HOLD_W-1:0];

            always @(posedge ref_clk)
            begin
                if (srst || route_write[ch])
                begin
                    div_cnt <= 6'd0;
                end
                else if (inc)
                begin
                    div_cnt <= div_pulse ? 6'd0 : div_cnt + 6'd1;
                end
            end

            always @(posedge ref_clk)
            begin
                if (srst || route_write[ch])
                begin
                    hold <= {`DOR_HOLD_W{1'b0}};
                end
                else if (hold != {`DOR_HOLD_W{1'b0}})
                begin
                    hold <= hold - {{(`DOR_HOLD_W-1){1'b0}}, 1'b1};
                end
                else if (div_pulse)
                begin
                    hold <= period - {{(`DOR_HOLD_W-1){1'b0}}, 1'b1};
                end
            end

            // Pulse is high for the first half of the hold-off window
            assign route_level[ch] = gate_ok & ((src == `DOR_SRC_ONE)
                | ((is_enc | is_pos) & (hold > {1'b0, period[`DOR_HOLD_W-1:1]})));
        end
    endgenerate

    // ----------------------------------------
    // Applied pattern and pins
    // ----------------------------------------
    reg [31:0] next_applied;

    always @*
    begin
        if (routing_on)
        begin
            next_applied = 32'h0000_0000;
            next_applied[`DOR_BRAKE_BIT] = output_value_word[`DOR_BRAKE_BIT];
            next_applied[`DOR_OUT1_BIT+3:`DOR_OUT1_BIT] = route_level[4:1];
        end
        else
        begin
            next_applied = normal_word;
        end
    end

    always @(posedge ref_clk)
    begin
        if (srst)
        begin
            output_applied_readback <= `DOR_READBACK_RESET;
            brake_o <= `DOR_PIN_RELEASED;
            brake_oe <= 1'b1;
            out_o <= 4'h0;
            out_oe <= 4'hf;
            pwm_out <= 1'b0;
        end
        else
        begin
            output_applied_readback <= next_applied;
            brake_o <= `DOR_PIN_RELEASED;
            // Open drain: a one releases the pin to the external pull-up
            brake_oe <= ~next_applied[`DOR_BRAKE_BIT];
            out_o <= 4'h0;
            out_oe <= ~next_applied[`DOR_OUT1_BIT+3:`DOR_OUT1_BIT];
            pwm_out <= routing_on & route_level[0];
        end
    end

endmodule

// >>> testbench/dor_output_routing_assertions.sv
// Port-level assertions for the output stage
`timescale 1ns/1ps
module dor_output_routing_checker #(
    parameter PWM_PERIOD_CYC = 20,
    parameter OUT_PERIOD_CYC = 40
) (
    input wire ref_clk,
    input wire srst,
    input wire [31:0] output_value_word,
    input wire [31:0] routing_gate_control_word,
    input wire [31:0] output_polarity_select,
    input wire [31:0] output_manual_enable,
    input wire [31:0] output_manual_value,
    input wire [31:0] output_routing_enable,
    input wire [15:0] route_output_one,
    input wire [31:0] output_applied_readback,
    input wire brake_o,
    input wire brake_oe,
    input wire [3:0] out_o,
    input wire [3:0] out_oe,
    input wire pwm_out
);
default clocking @(posedge ref_clk); endclocking
default disable iff (srst);
wire [31:0] app = ((output_value_word ^ output_polarity_select) & ~output_manual_enable)
    | (output_manual_value & output_manual_enable);
wire gate = routing_gate_control_word[route_output_one[4:0]] ^ route_output_one[7];
// Constant source with an in-range gate index only
wire cst = !srst && output_routing_enable[0] && route_output_one[15:9] == 7'h00
    && route_output_one[6:5] == 2'h0;
logic was_norm = 1'b0;
logic was_rt = 1'b0;
always @(posedge ref_clk)
begin
    was_norm <= !srst && !output_routing_enable[0];
    was_rt <= !srst && output_routing_enable[0];
end
AST_READBACK: assert property (was_norm |->
    output_applied_readback == ($past(app) & 32'h000f_0001)) else $error("bad readback");
AST_OUT_PINS: assert property (was_norm |-> out_oe == ~$past(app[19:16]))
    else $error("output pins wrong");
AST_BRAKE_PIN: assert property (was_norm |-> brake_oe == !$past(app[0]))
    else $error("brake pin wrong");
AST_OD_DATA: assert property (out_o == 4'h0 && !brake_o) else $error("pin data driven");
AST_PWM_IDLE: assert property (was_norm |-> !pwm_out) else $error("pwm active");
AST_BRAKE_ROUTED: assert property (was_rt |-> brake_oe == !$past(output_value_word[0]))
    else $error("brake not raw in routing");
AST_ROUTE_ON: assert property ((cst && !route_output_one[8] && gate)[*3] |-> !out_oe[0])
    else $error("constant one not driven");
AST_ROUTE_OFF: assert property ((cst && (route_output_one[8] || !gate))[*3] |-> out_oe[0])
    else $error("output not inactive");
endmodule
bind dor_output_routing dor_output_routing_checker #(.PWM_PERIOD_CYC(PWM_PERIOD_CYC),
    .OUT_PERIOD_CYC(OUT_PERIOD_CYC)) i_dor_output_routing_checker (.*);

// >>> testbench/dor_load_model.sv
// Open-drain loads with pull-ups on brake and output pins
`timescale 1ns/1ps
module dor_load_model (
    input wire brake_o,
    input wire brake_oe,
    input wire [3:0] out_o,
    input wire [3:0] out_oe,
    output wire [4:0] pin_level
);
// Released lines float up through the pull-up
assign pin_level = {out_oe & out_o | ~out_oe, brake_oe ? brake_o : 1'b1};
endmodule

// >>> testbench/dor_output_routing_test.sv
// Self-checking bench for the output stage
`timescale 1ns/1ps
module dor_output_routing_test;
logic ref_clk = 1'b0, srst = 1'b1, encoder_fitted = 1'b1, encoder_inc = 1'b0, position_inc = 1'b0;
logic [31:0] output_value_word = '0, routing_gate_control_word = '0, output_polarity_select = '0;
logic [31:0] output_manual_enable = '0, output_manual_value = '0, output_routing_enable = '0;
logic [15:0] route_pwm_output = '0, route_output_one = '0, route_output_two = '0;
logic [15:0] route_output_three = '0, route_output_four = '0;
logic [4:0] route_write = '0, pin_level;
logic [31:0] output_applied_readback;
logic [3:0] out_o, out_oe;
logic brake_o, brake_oe, pwm_out, last_pin = 1'b0;
int errors = 0, n_tests = 0, npulse = 0;
dor_output_routing #(.PWM_PERIOD_CYC(20), .OUT_PERIOD_CYC(40)) i_dor_output_routing (.*);
dor_load_model i_dor_load_model (.*);
always #2.5 ref_clk = ~ref_clk;
always @(posedge ref_clk)
begin
    npulse <= npulse + int'(pin_level[1] && !last_pin);
    last_pin <= pin_level[1];
end
task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
        errors++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
endtask
task automatic inc(bit enc, int g);
    encoder_inc = enc;
    position_inc = !enc;
    cyc(1);
    encoder_inc = 1'b0;
    position_inc = 1'b0;
    cyc(g);
endtask
task automatic rewrite(logic [15:0] entry);
    route_output_one = entry;
    route_write = 5'h02;
    cyc(1);
    route_write = 5'h00;
    cyc(60);
endtask
task automatic t_normal;
    logic [31:0] e;
    for (int k = 0; k < 4; k++)
    begin
        output_value_word = 32'hfff5_fffd;
        output_polarity_select = k[0] ? 32'hffff_ffff : 32'h0;
        output_manual_enable = k[1] ? 32'h0003_0001 : 32'h0;
        output_manual_value = 32'h0001_0000;
        e = ((output_value_word ^ output_polarity_select) & ~output_manual_enable)
            | (output_manual_value & output_manual_enable);
        cyc(2);
        check("readback", output_applied_readback, e & 32'h000f_0001);
        check("pins", pin_level, {e[19:16], e[0]});
    end
endtask
task automatic t_route;
    logic lv;
    output_routing_enable = 32'h1;
    output_value_word = 32'h0;
    output_manual_value = '1;
    for (int k = 0; k < 8; k++)
    begin
        routing_gate_control_word = k[2] ? 32'h20 : 32'h0;
        route_output_one = {7'h00, k[0], k[1], 7'h05};
        route_pwm_output = route_output_one;
        lv = !k[0] && (k[2] ^ k[1]);
        cyc(4);
        check("routed", pin_level[1], lv);
        check("pwm", pwm_out, lv);
        check("brake", pin_level[0], 1'b0);
        check("idle routes", pin_level[4:2], 3'h0);
    end
endtask
task automatic t_div;
    int n, p0;
    routing_gate_control_word = 32'h20;
    for (int c = 2; c < 16; c++)
    begin
        n = 1 << ((c - 2) % 7);
        rewrite({c[7:0], 8'h05});
        p0 = npulse;
        repeat (2 * n) inc(c < 9, 1 + 48 / n);
        cyc(50);
        check("divided", npulse - p0, 2);
    end
endtask
task automatic t_misc;
    int p0;
    rewrite(16'h0405);
    p0 = npulse;
    repeat (3) inc(1'b1, 20);
    rewrite(16'h0405);
    repeat (3) inc(1'b1, 20);
    check("cleared", npulse - p0, 0);
    encoder_fitted = 1'b0;
    rewrite(16'h0205);
    repeat (4) inc(1'b1, 50);
    check("hall", npulse - p0, 0);
    encoder_fitted = 1'b1;
    encoder_inc = 1'b1;
    cyc(80);
    encoder_inc = 1'b0;
    cyc(50);
    check("rate", npulse - p0, 2);
endtask
task automatic t_reset;
    output_value_word = 32'h000f_0001;
    srst = 1'b1;
    cyc(2);
    check("reset readback", output_applied_readback, 32'h0);
    check("reset pins", pin_level, 5'h00);
    check("reset pwm", pwm_out, 1'b0);
    srst = 1'b0;
    cyc(2);
    check("brake after reset", pin_level[0], 1'b1);
endtask
task automatic summarize;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
initial
begin
    cyc(5);
    srst = 1'b0;
    cyc(1);
    t_normal;
    t_route;
    t_div;
    t_misc;
    t_reset;
    summarize;
end
// Whole run needs well under 10k cycles
initial
begin
    #100us;
    errors++;
    summarize;
end
endmodule
